/* File: design/mie_map.svh */
// Constants for the instruction execution datapath
`ifndef MIE_MAP_SVH
`define MIE_MAP_SVH
`define MIE_BYTE_ZERO 8'h00
`define MIE_BYTE_ONE 8'h01
`define MIE_NIB_NINE 4'h9
`define MIE_NIB_SIX 4'h6
`define MIE_FLAG_RST 6'h00
`define MIE_WREG_RST 8'h00
`define MIE_TBL_RST 8'h00
`define MIE_PADDR_RST 16'h0000
`define MIE_LAST_PAGE 8'hff
`define MIE_DUMMY_CYC 1'b1
`endif

/* File: design/mie_pkg.sv */
// Types of the instruction execution datapath
`default_nettype none
package mie_pkg;
   typedef enum logic [4:0] {
      MIE_OP_NOP       = 5'h00,
      MIE_OP_NIB_SWAP  = 5'h01,
      MIE_OP_SKZ       = 5'h02,
      MIE_OP_SKZA      = 5'h03,
      MIE_OP_SKZBIT    = 5'h04,
      MIE_OP_TRD_PAGE  = 5'h05,
      MIE_OP_TRD_LAST  = 5'h06,
      MIE_OP_ITRD_PAGE = 5'h07,
      MIE_OP_ITRD_LAST = 5'h08,
      MIE_OP_XOR       = 5'h09,
      MIE_OP_XOR_IMM   = 5'h0a,
      MIE_OP_ADC       = 5'h0b,
      MIE_OP_ADD       = 5'h0c,
      MIE_OP_AND       = 5'h0d,
      MIE_OP_CLR       = 5'h0e,
      MIE_OP_CLRBIT    = 5'h0f,
      MIE_OP_CPL       = 5'h10,
      MIE_OP_DAA       = 5'h11,
      MIE_OP_DEC       = 5'h12,
      MIE_OP_INC       = 5'h13,
      MIE_OP_MOV       = 5'h14
   } mie_op_t;

   typedef enum logic [0:0] {
      MIE_ST_EXEC  = 1'b0,
      MIE_ST_DUMMY = 1'b1
   } mie_state_t;

   typedef struct packed {
      logic sgn_res;
      logic signed_range;
      logic z;
      logic half_carry;
      logic c;
      logic cz;
   } mie_flags_t;

   typedef struct packed {
      mie_op_t    op;
      logic       to_mem;
      logic [2:0] bit_sel;
      logic [7:0] imm;
   } mie_instr_t;

   typedef struct packed {
      logic       we;
      logic [7:0] wdata;
   } mie_mem_wr_t;

   typedef struct packed {
      mie_state_t  st;
      logic [7:0]  wreg;
      mie_flags_t  flags;
      logic [7:0]  tbl_lo;
      logic [7:0]  tbl_hi;
      logic [7:0]  tbl_hi_latch;
      mie_mem_wr_t dwr;
      logic        skip;
      logic        pm_rd;
      logic [15:0] pm_addr;
   } mie_state_reg_t;
endpackage : mie_pkg
`default_nettype wire

/* File: design/mie_exec.sv */
// Instruction execution datapath for the 8-bit core
// What this block does
// - Nibble swap into working register, memory untouched
// - Zero-test skip rewrites byte, skips on zero
// - Copy byte to working register, skip on zero
// - Skip when selected memory bit is zero
// - Basic skips take two cycles
// - Page table read: low to memory, high latched
// - Last-page table read uses pointer low only
// - Increment pointer low, then page table read
// - Increment pointer low, then last-page read
// - XOR with memory, destination by variant, zero flag
// - Immediate XOR into working register, zero flag
// - Extended access uses full address, no bank
// - Add with carry updates five arithmetic flags
// - Add without carry, same five flags
// - AND with memory, zero flag only
// - Clear byte or bit, no flags
// - Invert byte, destination by variant, zero flag
// - Decimal adjust working register into memory
// - Decimal adjust alters only carry
// - Decrement memory, destination by variant, zero flag
// - Increment memory, destination by variant, zero flag
// - Move memory byte to working register
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`default_nettype none
`include "mie_map.svh"
module mie_exec #(
   parameter int DADDR_W = 9,
   parameter int PADDR_W = 16
) (
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   input  wire logic                  clk_en,
   input  wire logic                  instr_valid,
   input  wire mie_pkg::mie_instr_t   instr,
   input  wire logic [DADDR_W-1:0]    instr_addr,
   input  wire logic [7:0]            mem_rdata,
   input  wire logic [15:0]           pm_rdata,
   input  wire logic                  tbl_lo_we,
   input  wire logic                  tbl_hi_we,
   input  wire logic [7:0]            tbl_wdata,
   output logic                       instr_ready,
   output logic [DADDR_W-1:0]         mem_addr,
   output logic                       mem_we,
   output logic [7:0]                 mem_wdata,
   output logic                       pm_rd,
   output logic [15:0]                pm_addr,
   output logic                       skip_next,
   output logic [7:0]                 working_register,
   output logic [7:0]                 table_pointer_low,
   output logic [7:0]                 table_pointer_high,
   output logic [7:0]                 table_high_latch,
   output mie_pkg::mie_flags_t        flags
);

   // ************************************************************
   // State
   // ************************************************************
   mie_pkg::mie_state_reg_t s_r;
   mie_pkg::mie_state_reg_t s_nxt;

   // ************************************************************
   // Arithmetic helpers
   // ************************************************************
   logic [7:0] m;
   logic [7:0] a;
   logic       cin;
   logic [4:0] lo_sum;
   logic [8:0] sum;
   logic       c6;
   logic [7:0] res;
   logic [7:0] daa_lo;
   logic [8:0] daa_sum;
   logic       lo_adj;
   logic       hi_adj;
   logic [7:0] tbl_inc;

   assign m = mem_rdata;
   assign a = s_r.wreg;
   // Carry is only folded in for the carry form
   assign cin = (instr.op == mie_pkg::MIE_OP_ADC) ? s_r.flags.c : 1'b0;
   assign lo_sum = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
   assign sum = {1'b0, a} + {1'b0, m} + {8'h00, cin};
   assign c6 = ({1'b0, a[6:0]} + {1'b0, m[6:0]}
                + {7'h00, cin}) >> 7 != 8'h00;
   assign lo_adj = (a[3:0] > `MIE_NIB_NINE) || s_r.flags.half_carry;
   assign daa_lo = lo_adj ? a + {4'h0, `MIE_NIB_SIX} : a;
   assign hi_adj = (daa_lo[7:4] > `MIE_NIB_NINE) || s_r.flags.c
                   || (lo_adj && (a[7:4] > daa_lo[7:4]));
   assign daa_sum = {1'b0, daa_lo}
                    + (hi_adj ? {1'b0, `MIE_NIB_SIX, 4'h0} : 9'h000);
   assign tbl_inc = s_r.tbl_lo + `MIE_BYTE_ONE;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      s_nxt = s_r;
      res = `MIE_BYTE_ZERO;
      s_nxt.dwr.we = 1'b0;
      s_nxt.dwr.wdata = `MIE_BYTE_ZERO;
      s_nxt.skip = 1'b0;
      s_nxt.pm_rd = 1'b0;
      if (tbl_lo_we) begin
         s_nxt.tbl_lo = tbl_wdata;
      end
      if (tbl_hi_we) begin
         s_nxt.tbl_hi = tbl_wdata;
      end
      if (s_r.st == mie_pkg::MIE_ST_DUMMY) begin
         // Dummy cycle while the skipped word is fetched
         s_nxt.st = mie_pkg::MIE_ST_EXEC;
      end else if (s_r.pm_rd) begin
         // Program word returns one cycle after the table address
         s_nxt.dwr.we = 1'b1;
         s_nxt.dwr.wdata = pm_rdata[7:0];
         s_nxt.tbl_hi_latch = pm_rdata[15:8];
      end else if (instr_valid) begin
         unique case (instr.op)
            mie_pkg::MIE_OP_NOP: begin
            end
            mie_pkg::MIE_OP_NIB_SWAP: begin
               s_nxt.wreg = {m[3:0], m[7:4]};
            end
            mie_pkg::MIE_OP_SKZ: begin
               s_nxt.dwr.we = 1'b1;
               s_nxt.dwr.wdata = m;
               s_nxt.skip = (m == `MIE_BYTE_ZERO);
               s_nxt.st = mie_pkg::MIE_ST_DUMMY;
            end
            mie_pkg::MIE_OP_SKZA: begin
               s_nxt.wreg = m;
               s_nxt.skip = (m == `MIE_BYTE_ZERO);
               s_nxt.st = mie_pkg::MIE_ST_DUMMY;
            end
            mie_pkg::MIE_OP_SKZBIT: begin
               s_nxt.skip = ~m[instr.bit_sel];
               s_nxt.st = mie_pkg::MIE_ST_DUMMY;
            end
            mie_pkg::MIE_OP_TRD_PAGE: begin
               s_nxt.pm_rd = 1'b1;
               s_nxt.pm_addr = {s_r.tbl_hi, s_r.tbl_lo};
            end
            mie_pkg::MIE_OP_TRD_LAST: begin
               s_nxt.pm_rd = 1'b1;
               s_nxt.pm_addr = {`MIE_LAST_PAGE, s_r.tbl_lo};
            end
            mie_pkg::MIE_OP_ITRD_PAGE: begin
               s_nxt.tbl_lo = tbl_inc;
               s_nxt.pm_rd = 1'b1;
               s_nxt.pm_addr = {s_r.tbl_hi, tbl_inc};
            end
            mie_pkg::MIE_OP_ITRD_LAST: begin
               s_nxt.tbl_lo = tbl_inc;
               s_nxt.pm_rd = 1'b1;
               s_nxt.pm_addr = {`MIE_LAST_PAGE, tbl_inc};
            end
            mie_pkg::MIE_OP_XOR, mie_pkg::MIE_OP_AND,
            mie_pkg::MIE_OP_CPL, mie_pkg::MIE_OP_DEC,
            mie_pkg::MIE_OP_INC: begin
               unique case (instr.op)
                  mie_pkg::MIE_OP_XOR: res = a ^ m;
                  mie_pkg::MIE_OP_AND: res = a & m;
                  mie_pkg::MIE_OP_CPL: res = ~m;
                  mie_pkg::MIE_OP_DEC: res = m - `MIE_BYTE_ONE;
                  default: res = m + `MIE_BYTE_ONE;
               endcase
               s_nxt.flags.z = (res == `MIE_BYTE_ZERO);
               if (instr.to_mem) begin
                  s_nxt.dwr.we = 1'b1;
                  s_nxt.dwr.wdata = res;
               end else begin
                  s_nxt.wreg = res;
               end
            end
            mie_pkg::MIE_OP_XOR_IMM: begin
               res = a ^ instr.imm;
               s_nxt.wreg = res;
               s_nxt.flags.z = (res == `MIE_BYTE_ZERO);
            end
            mie_pkg::MIE_OP_ADC, mie_pkg::MIE_OP_ADD: begin
               res = sum[7:0];
               s_nxt.flags.c = sum[8];
               s_nxt.flags.half_carry = lo_sum[4];
               s_nxt.flags.signed_range = sum[8] ^ c6;
               s_nxt.flags.z = (res == `MIE_BYTE_ZERO);
               // True sign of the sum, overflow folded in
               s_nxt.flags.sgn_res = ((sum[8] ^ c6) ? ~res[7] : res[7]);
               if (instr.to_mem) begin
                  s_nxt.dwr.we = 1'b1;
                  s_nxt.dwr.wdata = res;
               end else begin
                  s_nxt.wreg = res;
               end
            end
            mie_pkg::MIE_OP_CLR: begin
               s_nxt.dwr.we = 1'b1;
               s_nxt.dwr.wdata = `MIE_BYTE_ZERO;
            end
            mie_pkg::MIE_OP_CLRBIT: begin
               s_nxt.dwr.we = 1'b1;
               s_nxt.dwr.wdata = m & ~(`MIE_BYTE_ONE << instr.bit_sel);
            end
            mie_pkg::MIE_OP_DAA: begin
               s_nxt.dwr.we = 1'b1;
               s_nxt.dwr.wdata = daa_sum[7:0];
               // Carry is only ever set here so chained sums stay intact
               s_nxt.flags.c = s_r.flags.c | hi_adj | daa_sum[8];
            end
            mie_pkg::MIE_OP_MOV: begin
               s_nxt.wreg = m;
            end
            default: begin
            end
         endcase
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_r.st <= mie_pkg::MIE_ST_EXEC;
         s_r.wreg <= `MIE_WREG_RST;
         s_r.flags <= `MIE_FLAG_RST;
         s_r.tbl_lo <= `MIE_TBL_RST;
         s_r.tbl_hi_latch <= `MIE_TBL_RST;
         s_r.dwr <= '0;
         s_r.skip <= 1'b0;
         s_r.pm_rd <= 1'b0;
         s_r.pm_addr <= `MIE_PADDR_RST;
         s_r.tbl_hi <= `MIE_TBL_RST;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Address is the instruction's full address, no bank bits added
   assign mem_addr = instr_addr;
   assign mem_we = s_r.dwr.we & clk_en;
   assign mem_wdata = s_r.dwr.wdata;
   assign pm_rd = s_r.pm_rd;
   assign pm_addr = s_r.pm_addr;
   assign skip_next = s_r.skip;
   assign instr_ready = (s_r.st == mie_pkg::MIE_ST_EXEC) && !s_r.pm_rd;
   assign working_register = s_r.wreg;
   assign table_pointer_low = s_r.tbl_lo;
   assign table_pointer_high = s_r.tbl_hi;
   assign table_high_latch = s_r.tbl_hi_latch;
   assign flags = s_r.flags;

endmodule : mie_exec
`default_nettype wire

/* File: dv/mie_mem_model.sv */
// Data and program memory model facing the execution datapath
`default_nettype none
module mie_mem_model (
   input  wire logic        mclk,
   input  wire logic [8:0]  mem_addr,
   input  wire logic        mem_we,
   input  wire logic [7:0]  mem_wdata,
   output logic [7:0]       mem_rdata,
   input  wire logic        pm_rd,
   input  wire logic [15:0] pm_addr,
   output logic [15:0]      pm_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] dmem [0:511];
   // Word differs per address; inverted outside a read so stale use shows
   assign pm_rdata = {16{~pm_rd}}
                     ^ {~pm_addr[7:0], pm_addr[7:0] ^ pm_addr[15:8]};
   assign mem_rdata = dmem[mem_addr];
   always @(posedge mclk) begin
      if (mem_we) dmem[mem_addr] <= mem_wdata;
   end
endmodule : mie_mem_model
`default_nettype wire

/* File: dv/mie_exec_monitor.sv */
// Concurrent checks on the execution datapath ports
`default_nettype none
module mie_exec_monitor (
   input wire logic                mclk,
   input wire logic                rst_n,
   input wire logic                clk_en,
   input wire logic                instr_valid,
   input wire mie_pkg::mie_instr_t instr,
   input wire logic [7:0]          mem_rdata,
   input wire logic [15:0]         pm_rdata,
   input wire logic                instr_ready,
   input wire logic                mem_we,
   input wire logic [7:0]          mem_wdata,
   input wire logic                pm_rd,
   input wire logic [15:0]         pm_addr,
   input wire logic                skip_next,
   input wire logic [7:0]          working_register,
   input wire logic [7:0]          table_pointer_low,
   input wire logic [7:0]          table_pointer_high,
   input wire logic [7:0]          table_high_latch,
   input wire mie_pkg::mie_flags_t flags
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   mie_pkg::mie_op_t op;
   logic             bz;
   // Op reads as idle unless the instruction is really taken
   assign op = (instr_valid && instr_ready && clk_en) ? instr.op
                                                     : mie_pkg::MIE_OP_NOP;
   assign bz = !mem_rdata[instr.bit_sel];
   a_swap_result: assert property (op == mie_pkg::MIE_OP_NIB_SWAP |=>
      working_register == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}
      && $stable(flags)) else $error("nibble swap wrong");
   a_zero_skip: assert property (op == mie_pkg::MIE_OP_SKZ |=>
      mem_we && mem_wdata == $past(mem_rdata)
      && skip_next == ($past(mem_rdata) == 8'h00)) else $error("zero skip");
   a_copy_skip: assert property (op == mie_pkg::MIE_OP_SKZA |=>
      working_register == $past(mem_rdata) && $stable(flags)
      && skip_next == ($past(mem_rdata) == 8'h00)) else $error("copy skip");
   a_bit_skip: assert property (op == mie_pkg::MIE_OP_SKZBIT |=>
      skip_next == $past(bz)) else $error("bit skip wrong");
   a_skip_dummy: assert property (op inside {mie_pkg::MIE_OP_SKZ,
      mie_pkg::MIE_OP_SKZA, mie_pkg::MIE_OP_SKZBIT}
      |=> !instr_ready ##1 instr_ready) else $error("skip not two cycles");
   a_page_addr: assert property (op == mie_pkg::MIE_OP_TRD_PAGE |=>
      pm_rd && pm_addr == {$past(table_pointer_high),
      $past(table_pointer_low)}) else $error("page table address");
   a_last_addr: assert property (op inside {mie_pkg::MIE_OP_TRD_LAST,
      mie_pkg::MIE_OP_ITRD_LAST} |=> pm_rd && pm_addr[15:8] == 8'hff
      && pm_addr[7:0] == table_pointer_low) else $error("last page address");
   a_ptr_incr: assert property (op inside {mie_pkg::MIE_OP_ITRD_PAGE,
      mie_pkg::MIE_OP_ITRD_LAST} |=> pm_addr[7:0] == table_pointer_low
      && table_pointer_low == $past(table_pointer_low) + 8'h01)
      else $error("pointer increment");
   a_table_return: assert property (pm_rd |=> mem_we
      && mem_wdata == $past(pm_rdata[7:0])
      && table_high_latch == $past(pm_rdata[15:8])) else $error("table data");
   a_xor_imm: assert property (op == mie_pkg::MIE_OP_XOR_IMM |=>
      working_register == ($past(working_register) ^ $past(instr.imm))
      && flags.z == (working_register == 8'h00)) else $error("xor immediate");
   c_skip: cover property (op == mie_pkg::MIE_OP_SKZ ##1 skip_next);
   c_table: cover property (pm_rd ##1 mem_we);
   c_adjust: cover property (op == mie_pkg::MIE_OP_DAA);
endmodule : mie_exec_monitor
bind mie_exec mie_exec_monitor u_mon (.*);
`default_nettype wire

/* File: dv/mie_exec_tb.sv */
// Self-checking testbench for the execution datapath
`default_nettype none
module mie_exec_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, instr_valid, tbl_lo_we, tbl_hi_we, mem_we, pm_rd;
   logic skip_next, instr_ready, skp, clk_en;
   logic [7:0] tbl_wdata, mem_rdata, mem_wdata, working_register;
   logic [7:0] table_pointer_low, table_pointer_high, table_high_latch;
   logic [8:0] instr_addr, mem_addr, a;
   logic [15:0] pm_rdata, pm_addr;
   mie_pkg::mie_instr_t instr;
   mie_pkg::mie_flags_t flags;
   int error_cnt, n_tests, cyc;
   mie_exec dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
      .instr_valid(instr_valid), .instr(instr), .instr_addr(instr_addr),
      .mem_rdata(mem_rdata), .pm_rdata(pm_rdata), .tbl_lo_we(tbl_lo_we),
      .tbl_hi_we(tbl_hi_we), .tbl_wdata(tbl_wdata),
      .instr_ready(instr_ready), .mem_addr(mem_addr), .mem_we(mem_we),
      .mem_wdata(mem_wdata), .pm_rd(pm_rd), .pm_addr(pm_addr),
      .skip_next(skip_next), .working_register(working_register),
      .table_pointer_low(table_pointer_low),
      .table_pointer_high(table_pointer_high),
      .table_high_latch(table_high_latch), .flags(flags));
   mie_mem_model u_mem (.mclk(mclk), .mem_addr(mem_addr), .mem_we(mem_we),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .pm_rd(pm_rd),
      .pm_addr(pm_addr), .pm_rdata(pm_rdata));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic test_done;
      $display("Mismatches %0d of %0d checks", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done
   // Whole run needs about 160 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // ********************************
   // One instruction; imm low bits double as bit select
   // ********************************
   task automatic run(input mie_pkg::mie_op_t op, input logic tm,
      input logic [7:0] imm, input logic [8:0] ad, input logic [7:0] v);
      a = ad;
      u_mem.dmem[ad] = v;
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr <= '{op, tm, imm[2:0], imm};
      instr_addr <= ad;
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1 skp = skip_next;
      repeat (3) @(posedge mclk);
      #1;
   endtask : run
   task automatic tp(input logic [7:0] hi, input logic [7:0] lo);
      @(posedge mclk);
      tbl_lo_we <= 1'b1;
      tbl_wdata <= lo;
      @(posedge mclk);
      tbl_lo_we <= 1'b0;
      tbl_hi_we <= 1'b1;
      tbl_wdata <= hi;
      @(posedge mclk);
      tbl_hi_we <= 1'b0;
   endtask : tp
   initial begin
      {rst_n, instr_valid, tbl_lo_we, tbl_hi_we, tbl_wdata} = '0;
      clk_en = 1'b1;
      instr = '0;
      instr_addr = '0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      run(mie_pkg::MIE_OP_MOV, 0, 0, 9'h1a5, 8'h3c);
      chk(working_register, 8'h3c);
      run(mie_pkg::MIE_OP_NIB_SWAP, 0, 0, 9'h010, 8'h5a);
      chk({working_register, u_mem.dmem[a]}, 16'ha55a);
      run(mie_pkg::MIE_OP_SKZ, 0, 0, 9'h011, 8'h00);
      chk({skp, u_mem.dmem[a]}, 16'h100);
      run(mie_pkg::MIE_OP_SKZ, 0, 0, 9'h011, 8'h07);
      chk({skp, u_mem.dmem[a]}, 16'h007);
      run(mie_pkg::MIE_OP_SKZA, 0, 0, 9'h012, 8'h00);
      chk({skp, working_register}, 16'h100);
      run(mie_pkg::MIE_OP_SKZBIT, 0, 8'h07, 9'h013, 8'h7f);
      chk(skp, 1);
      run(mie_pkg::MIE_OP_SKZBIT, 0, 8'h00, 9'h013, 8'h7f);
      chk(skp, 0);
      run(mie_pkg::MIE_OP_MOV, 0, 0, 9'h014, 8'hf0);
      run(mie_pkg::MIE_OP_XOR_IMM, 0, 8'hf0, 9'h014, 8'hf0);
      chk({flags.z, working_register}, 16'h100);
      run(mie_pkg::MIE_OP_XOR, 1, 0, 9'h015, 8'h33);
      chk({flags.z, u_mem.dmem[a]}, 16'h033);
      run(mie_pkg::MIE_OP_MOV, 0, 0, 9'h016, 8'h7f);
      run(mie_pkg::MIE_OP_ADD, 0, 0, 9'h016, 8'h01);
      chk({flags, working_register}, 16'h1480);
      run(mie_pkg::MIE_OP_ADD, 1, 0, 9'h017, 8'h80);
      chk({flags, u_mem.dmem[a]}, 16'h3a00);
      run(mie_pkg::MIE_OP_ADC, 0, 0, 9'h018, 8'h01);
      chk({flags, working_register}, 16'h2082);
      run(mie_pkg::MIE_OP_AND, 1, 0, 9'h019, 8'h7d);
      chk({flags, u_mem.dmem[a]}, 16'h2800);
      run(mie_pkg::MIE_OP_CLR, 0, 0, 9'h01a, 8'hff);
      chk({flags, u_mem.dmem[a]}, 16'h2800);
      run(mie_pkg::MIE_OP_CLRBIT, 0, 8'h03, 9'h01b, 8'hff);
      chk(u_mem.dmem[a], 8'hf7);
      run(mie_pkg::MIE_OP_CPL, 0, 0, 9'h01c, 8'h0f);
      chk({flags.z, working_register, u_mem.dmem[a][6:0]}, 16'h780f);
      run(mie_pkg::MIE_OP_CPL, 1, 0, 9'h01d, 8'hff);
      chk({flags.z, u_mem.dmem[a]}, 16'h100);
      run(mie_pkg::MIE_OP_MOV, 0, 0, 9'h01e, 8'h3c);
      run(mie_pkg::MIE_OP_DAA, 1, 0, 9'h01e, 8'h00);
      chk({flags, u_mem.dmem[a]}, 16'h2842);
      run(mie_pkg::MIE_OP_MOV, 0, 0, 9'h01f, 8'ha3);
      run(mie_pkg::MIE_OP_DAA, 1, 0, 9'h01f, 8'h00);
      chk({flags, u_mem.dmem[a]}, 16'h2a03);
      run(mie_pkg::MIE_OP_INC, 1, 0, 9'h020, 8'hff);
      chk({flags.z, u_mem.dmem[a]}, 16'h100);
      run(mie_pkg::MIE_OP_DEC, 0, 0, 9'h021, 8'h00);
      chk({flags.z, working_register, u_mem.dmem[a][6:0]}, 16'h7f80);
      // Enable held low: the offered increment must not be taken
      @(posedge mclk);
      clk_en <= 1'b0;
      run(mie_pkg::MIE_OP_INC, 1, 0, 9'h026, 8'h55);
      chk({working_register, u_mem.dmem[a]}, 16'hff55);
      @(posedge mclk);
      clk_en <= 1'b1;
      tp(8'h12, 8'h34);
      run(mie_pkg::MIE_OP_TRD_PAGE, 0, 0, 9'h022, 8'h00);
      chk({table_high_latch, u_mem.dmem[a]}, 16'hcb26);
      run(mie_pkg::MIE_OP_TRD_LAST, 0, 0, 9'h023, 8'h00);
      chk({table_high_latch, u_mem.dmem[a]}, 16'hcbcb);
      run(mie_pkg::MIE_OP_ITRD_PAGE, 0, 0, 9'h024, 8'h00);
      chk({table_high_latch, u_mem.dmem[a]}, 16'hca27);
      tp(8'h12, 8'hff);
      run(mie_pkg::MIE_OP_ITRD_LAST, 0, 0, 9'h025, 8'h00);
      chk({table_pointer_high, table_pointer_low}, 16'h1200);
      chk({table_high_latch, u_mem.dmem[a]}, 16'hffff);
      test_done();
   end
endmodule : mie_exec_tb
`default_nettype wire
